// ==== design/acs_pkg.sv ====
// acs_pkg: constants, register map and carrier types of the conversion sequencer.
// assumes a 32-bit classic wishbone slave on a 50 MHz clock and a synchronous analog macro.
// Functional notes
// - software mode: start on software request only
// - hardware no-wait: trigger starts conversion, powered already
// - hardware wait: power on trigger, wait, convert
// - select mode converts one chosen channel
// - scan mode converts four ascending channels
// - one-shot: one pass per trigger, then standby
// - sequential: repeat until software clears request
// - sampling length programmable, default 13.5 clocks
// - conversion length never below 31.5 clocks
// - each conversion yields a 12-bit result
// - fifteen external inputs numbered from zero
// - internal reference and temperature sensor selectable
// - self-test converts both reference levels too
package acs_pkg;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL   = 6'h00;  // mode and request bits
  localparam logic [5:0] OFS_CHSEL  = 6'h04;  // channel code or scan base
  localparam logic [5:0] OFS_SAMP   = 6'h08;  // sampling length, half clocks
  localparam logic [5:0] OFS_CONV   = 6'h0C;  // conversion length, half clocks
  localparam logic [5:0] OFS_RESULT = 6'h10;  // last result with its channel
  localparam logic [5:0] OFS_STATUS = 6'h14;  // sticky events, write one clears
  localparam logic [5:0] OFS_MASK   = 6'h18;  // interrupt enables
  localparam logic [5:0] OFS_STATE  = 6'h1C;  // live sequencer state

  // trigger modes; the unused code behaves as software mode
  localparam logic [1:0] TRIG_SW     = 2'h0;
  localparam logic [1:0] TRIG_HW_NOW = 2'h1;
  localparam logic [1:0] TRIG_HW_WT  = 2'h2;

  // channel codes
  localparam int         CH_W        = 5;
  localparam int         RES_W       = 12;
  localparam logic [4:0] CH_EXT_LAST = 5'h0E;  // fifteen external inputs, 0 to 14
  localparam logic [4:0] CH_TEMP     = 5'h10;  // temperature sensor
  localparam logic [4:0] CH_VREF     = 5'h11;  // internal 1.45 V reference
  localparam logic [4:0] CH_REFP     = 5'h12;  // positive reference, self-test
  localparam logic [4:0] CH_REFN     = 5'h13;  // negative reference, self-test
  localparam logic [1:0] SCAN_LAST   = 2'h3;   // four channels per scan pass
  localparam logic [3:0] SCAN_BMAX   = 4'hB;   // highest base keeping four inside 0..14

  // phase lengths in half converter clocks
  localparam logic [7:0] SAMP_DEF = 8'h1B;  // 13.5 clocks
  localparam logic [7:0] SAMP_MIN = 8'h01;
  localparam logic [7:0] CONV_MIN = 8'h3F;  // 31.5 clocks

  // timing
  localparam int CLK_NS  = 20;
  localparam int STAB_NS = 1000;  // analog stabilisation wait
  localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W   = 12;

  // status and mask bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_EOC  = 0;  // one channel converted
  localparam int IRQ_PASS = 1;  // a whole pass finished
  localparam int IRQ_OVR  = 2;  // trigger arrived while busy

  localparam int TRIG_N = 4;

  // control register layout, bit 0 is run
  typedef struct packed {
    logic [1:0] trig_sel;   // which hardware trigger input
    logic       seq;        // sequential when set, else one-shot
    logic       scan;       // scan when set, else select
    logic [1:0] trig_mode;  // trigger mode code
    logic       run;        // operation request
  } acs_ctrl_type;

  localparam acs_ctrl_type CTRL_RST = 7'h00;

  // controls toward the analog macro
  typedef struct packed {
    logic            pwr;      // analog section powered
    logic            sample;   // sampling switch closed
    logic            convert;  // conversion running
    logic [CH_W-1:0] chan;     // multiplexer code
  } acs_ana_type;

endpackage : acs_pkg

// ==== design/acs_sequencer.sv ====
// acs_sequencer: control logic of the 12-bit converter with a wishbone register file.
// assumes a synchronous analog macro whose result is valid at the end of conversion.
`timescale 1ns/10ps
module acs_sequencer #(
  parameter int STAB_CYCLES = acs_pkg::STAB_CYC  // stabilisation wait in clocks
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // classic wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [5:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // hardware trigger sources, asynchronous
  input  wire logic [acs_pkg::TRIG_N-1:0] hw_trig_i,
  // analog macro
  input  wire logic [acs_pkg::RES_W-1:0] adc_data_i,
  output acs_pkg::acs_ana_type          ana_o,
  // interrupt, level
  output logic                          irq_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PWRUP,
    ST_SAMPLE,
    ST_CONVERT
  } acs_state_type;

  acs_state_type         state_r;    // sequencer state
  acs_state_type         state_nxt;
  acs_pkg::acs_ctrl_type ctrl_r;     // mode register
  logic [acs_pkg::CH_W-1:0] chsel_r; // channel code or scan base
  logic [7:0]            samp_r;     // sampling half clocks
  logic [7:0]            conv_r;     // conversion half clocks
  logic [acs_pkg::RES_W-1:0] res_r;  // last result
  logic [acs_pkg::CH_W-1:0] res_ch_r; // channel of last result
  logic [acs_pkg::IRQ_W-1:0] sts_r;  // sticky events
  logic [acs_pkg::IRQ_W-1:0] mask_r; // interrupt enables
  logic [acs_pkg::CNT_W-1:0] cnt_r;  // phase down-counter
  logic [1:0]            idx_r;      // position in scan pass
  logic [acs_pkg::TRIG_N-1:0] trig_rise; // synchronised edges

  logic                  wr_req;     // a write strobe this cycle
  logic                  rd_req;     // a read strobe this cycle
  logic [31:0]           wmask;      // byte lanes as bit mask
  logic [31:0]           rd_val;     // read mux
  logic                  trig_evt;   // selected trigger edge
  logic                  start_go;   // begin a pass from idle
  logic                  phase_end;  // counter reached zero
  logic                  chan_done;  // one conversion completes
  logic                  pass_done;  // last channel of the pass completes
  logic                  restart;    // sequential mode goes round again
  logic                  hw_mode;    // one of the hardware modes
  logic [3:0]            scan_base;  // clamped scan start
  logic [acs_pkg::CH_W-1:0] cur_ch;  // channel now on the multiplexer
  logic [acs_pkg::CNT_W-1:0] samp_cyc; // sampling clocks, rounded up
  logic [acs_pkg::CNT_W-1:0] conv_cyc; // conversion clocks, rounded up
  logic [acs_pkg::IRQ_W-1:0] sts_set; // events this cycle
  logic [1:0]            idx_nxt;    // scan position after this edge
  logic [acs_pkg::CH_W-1:0] chan_nxt; // channel the mux shows after this edge

  // trigger synchronisers live in the leaf so no logic reads a first stage
  acs_trig_sync #(
    .N (acs_pkg::TRIG_N)
  ) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .trig_i (hw_trig_i),
    .rise_o (trig_rise)
  );

  // bus strobes; ack is one clock after the strobe and drops the next
  assign wr_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;
  assign rd_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // merge write data into an old value through the byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (wb_dat_i & wmask);
  endfunction : merge

  // half clocks to whole clocks, rounded up so no phase runs short
  assign samp_cyc = acs_pkg::CNT_W'((samp_r + 9'h001) >> 1);
  assign conv_cyc = acs_pkg::CNT_W'((conv_r + 9'h001) >> 1);

  // unused trigger code falls back to software so every setting is legal
  assign hw_mode  = (ctrl_r.trig_mode == acs_pkg::TRIG_HW_NOW) |
                    (ctrl_r.trig_mode == acs_pkg::TRIG_HW_WT);
  assign trig_evt = hw_mode & trig_rise[ctrl_r.trig_sel];

  // software mode needs only the request; hardware modes need an edge too
  assign start_go = ctrl_r.run & (hw_mode ? trig_evt : 1'b1);

  // scan base is kept low enough that four channels stay external
  assign scan_base = (chsel_r[3:0] > acs_pkg::SCAN_BMAX) ? acs_pkg::SCAN_BMAX :
                     chsel_r[3:0];
  // select mode passes any code, external or internal, straight to the mux
  assign cur_ch = ctrl_r.scan ? {1'b0, scan_base + {2'b00, idx_r}} :
                  chsel_r;
  // the mux must already show the coming channel when its sampling phase opens,
  // otherwise the first sampling clock of each scan step sees the old input
  assign idx_nxt  = (state_nxt == ST_IDLE || pass_done) ? 2'h0 :
                    chan_done ? idx_r + 2'h1 : idx_r;
  assign chan_nxt = ctrl_r.scan ? {1'b0, scan_base + {2'b00, idx_nxt}} : chsel_r;

  assign phase_end = (cnt_r == '0);
  assign chan_done = (state_r == ST_CONVERT) & phase_end;
  assign pass_done = chan_done & (~ctrl_r.scan | (idx_r == acs_pkg::SCAN_LAST));
  assign restart   = pass_done & ctrl_r.seq & ctrl_r.run;

  // next state; clearing the request aborts at once
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_go) begin
          if (ctrl_r.trig_mode == acs_pkg::TRIG_HW_WT) begin
            state_nxt = ST_PWRUP;
          end else begin
            state_nxt = ST_SAMPLE;
          end
        end
      end
      ST_PWRUP: begin
        if (!ctrl_r.run) begin
          state_nxt = ST_IDLE;
        end else if (phase_end) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (!ctrl_r.run) begin
          state_nxt = ST_IDLE;
        end else if (phase_end) begin
          state_nxt = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!ctrl_r.run) begin
          state_nxt = ST_IDLE;
        end else if (chan_done) begin
          // more channels or another round, else back to standby
          if (!pass_done || restart) begin
            state_nxt = ST_SAMPLE;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // phase counter, loaded on each entry into a timed state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (state_nxt == ST_PWRUP && state_r != ST_PWRUP) begin
      cnt_r <= acs_pkg::CNT_W'(STAB_CYCLES - 1);
    end else if (state_nxt == ST_SAMPLE && state_r != ST_SAMPLE) begin
      cnt_r <= samp_cyc - 1'b1;
    end else if (state_nxt == ST_CONVERT && state_r != ST_CONVERT) begin
      cnt_r <= conv_cyc - 1'b1;
    end else if (!phase_end) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // scan position: steps per channel, wraps at the end of a pass
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_r <= '0;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  // result capture at the end of each conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_r    <= '0;
      res_ch_r <= '0;
    end else if (chan_done && ctrl_r.run) begin
      res_r    <= adc_data_i;
      res_ch_r <= cur_ch;
    end
  end

  // control register; a one-shot software pass drops the request itself,
  // but a software write in the same cycle overrides that clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= acs_pkg::CTRL_RST;
    end else if (wr_req && wb_adr_i == acs_pkg::OFS_CTRL) begin
      ctrl_r <= acs_pkg::acs_ctrl_type'(merge(32'({ctrl_r})));
    end else if (pass_done && !ctrl_r.seq && !hw_mode) begin
      ctrl_r.run <= 1'b0;
    end
  end

  // channel and timing registers; conversion length is floored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chsel_r <= '0;
      samp_r  <= acs_pkg::SAMP_DEF;
      conv_r  <= acs_pkg::CONV_MIN;
    end else if (wr_req) begin
      if (wb_adr_i == acs_pkg::OFS_CHSEL) begin
        chsel_r <= acs_pkg::CH_W'(merge(32'(chsel_r)));
      end
      if (wb_adr_i == acs_pkg::OFS_SAMP) begin
        // a zero length would wrap the counter and hold the sampling phase for 4096 clocks
        if (merge(32'(samp_r)) < 32'(acs_pkg::SAMP_MIN)) begin
          samp_r <= acs_pkg::SAMP_MIN;
        end else begin
          samp_r <= 8'(merge(32'(samp_r)));
        end
      end
      if (wb_adr_i == acs_pkg::OFS_CONV) begin
        if (8'(merge(32'(conv_r))) < acs_pkg::CONV_MIN) begin
          conv_r <= acs_pkg::CONV_MIN;
        end else begin
          conv_r <= 8'(merge(32'(conv_r)));
        end
      end
    end
  end

  // event sources for the sticky status
  always_comb begin
    sts_set                    = '0;
    sts_set[acs_pkg::IRQ_EOC]  = chan_done & ctrl_r.run;
    sts_set[acs_pkg::IRQ_PASS] = pass_done & ctrl_r.run;
    // a trigger while a pass runs is dropped; this makes it visible
    sts_set[acs_pkg::IRQ_OVR]  = trig_evt & (state_r != ST_IDLE);
  end

  // sticky status, write one clears, a new event wins over its clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_r <= '0;
    end else if (wr_req && wb_adr_i == acs_pkg::OFS_STATUS) begin
      sts_r <= (sts_r & ~acs_pkg::IRQ_W'(wb_dat_i & wmask)) | sts_set;
    end else begin
      sts_r <= sts_r | sts_set;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= '0;
    end else if (wr_req && wb_adr_i == acs_pkg::OFS_MASK) begin
      mask_r <= acs_pkg::IRQ_W'(merge(32'(mask_r)));
    end
  end

  // interrupt level, registered so it lags the status by one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sts_r & mask_r);
    end
  end

  // analog controls, registered from the next state so they align with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_o <= '0;
    end else begin
      // wait mode keeps the analog section off while idle
      ana_o.pwr     <= (state_nxt != ST_IDLE) |
                       (ctrl_r.run & (ctrl_r.trig_mode != acs_pkg::TRIG_HW_WT));
      ana_o.sample  <= (state_nxt == ST_SAMPLE);
      ana_o.convert <= (state_nxt == ST_CONVERT);
      ana_o.chan    <= chan_nxt;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_val = '0;
    unique case (wb_adr_i)
      acs_pkg::OFS_CTRL:   rd_val = 32'({ctrl_r});
      acs_pkg::OFS_CHSEL:  rd_val = 32'(chsel_r);
      acs_pkg::OFS_SAMP:   rd_val = 32'(samp_r);
      acs_pkg::OFS_CONV:   rd_val = 32'(conv_r);
      acs_pkg::OFS_RESULT: rd_val = {11'h000, res_ch_r, 4'h0, res_r};
      acs_pkg::OFS_STATUS: rd_val = 32'(sts_r);
      acs_pkg::OFS_MASK:   rd_val = 32'(mask_r);
      acs_pkg::OFS_STATE:  rd_val = {19'h00000, cur_ch, 2'h0, idx_r,
                                     ana_o.pwr, 1'b0, state_r};
      default:             rd_val = '0;
    endcase
  end

  // bus answer, one clock after the strobe, every address acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wr_req | rd_req;
      if (rd_req) begin
        wb_dat_o <= rd_val;
      end
    end
  end

endmodule : acs_sequencer

// ==== design/acs_trig_sync.sv ====
// acs_trig_sync: two-stage synchronisers and rising-edge pulses for trigger inputs.
// assumes triggers are asynchronous levels held at least two clocks.
`timescale 1ns/10ps
module acs_trig_sync #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] trig_i,
  output logic      [N-1:0] rise_o
);

  logic [N-1:0] meta_r;  // first stage, read only by the second
  logic [N-1:0] sync_r;  // settled level
  logic [N-1:0] old_r;   // previous settled level

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // synchroniser chain and edge pulse per input
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          old_r[g]  <= 1'b0;
          rise_o[g] <= 1'b0;
        end else begin
          meta_r[g] <= trig_i[g];
          sync_r[g] <= meta_r[g];
          old_r[g]  <= sync_r[g];
          rise_o[g] <= sync_r[g] & ~old_r[g];
        end
      end
    end
  endgenerate

endmodule : acs_trig_sync

// ==== dv/acs_ana_model.sv ====
// acs_ana_model: analog macro and trigger pins facing the sequencer.
// assumes data is trusted only while the conversion phase is up.
`timescale 1ns/10ps
module acs_ana_model (
  input  wire logic                 clk_i,
  input  wire acs_pkg::acs_ana_type ana_i,
  input  wire logic [3:0]           fire_i,
  output logic      [11:0]          adc_data_o,
  output logic      [3:0]           trig_o
);
  logic [11:0] junk_r = 12'h5A3;  // toggles so a stale capture is seen
  // pattern outside conversion changes every cycle
  always_ff @(posedge clk_i) begin
    junk_r <= ~junk_r;
  end
  // result carries the channel so inputs can be told apart
  assign adc_data_o = ana_i.convert ? {4'hA, 3'h0, ana_i.chan} : junk_r;
  // trigger pins follow the source request level
  assign trig_o = fire_i;
endmodule : acs_ana_model

// ==== dv/acs_sequencer_tb_top.sv ====
// acs_sequencer_tb_top: directed bench for the conversion sequencer.
// assumes a 50 MHz clock and the register map of the sequencer package.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module acs_sequencer_tb_top;
  localparam int STAB = 4;  // short wait keeps the run brief
  logic                 clk_i;
  logic                 rst_i;
  logic                 wb_cyc;
  logic                 wb_stb;
  logic                 wb_we;
  logic [5:0]           wb_adr;
  logic [3:0]           wb_sel;
  logic [31:0]          wb_wdat;
  logic [31:0]          wb_rdat;
  logic                 wb_ack;
  logic [3:0]           fire;     // trigger source request
  logic [3:0]           hw_trig;
  logic [11:0]          adc_data;
  acs_pkg::acs_ana_type ana;
  logic                 irq;
  logic                 smp_q;    // sample level at the previous edge
  logic [4:0]           chq[$];   // channel of each sampling phase
  int                   err_total;
  int                   checked;
  acs_sequencer #(.STAB_CYCLES(STAB)) u_acs_sequencer (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .hw_trig_i(hw_trig), .adc_data_i(adc_data), .ana_o(ana), .irq_o(irq));
  acs_ana_model u_acs_ana_model (.clk_i(clk_i), .ana_i(ana), .fire_i(fire),
    .adc_data_o(adc_data), .trig_o(hw_trig));
  // clock generator
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  // record each channel when sampling starts
  always @(posedge clk_i) begin
    if (ana.sample === 1'h1 && smp_q !== 1'h1) chq.push_back(ana.chan);
    smp_q = ana.sample;
  end
  // classic single cycle; waits for ack, then releases
  task automatic wb_io(input logic we, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'h1 && n < 50);
    if (n >= 50) err_total++;
    q = wb_rdat;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clk_i);
  endtask : wb_io
  // wait for the interrupt, check the last result and the n sampled channels ending with it
  task automatic chk_res(input logic [4:0] ch, input int nch);
    logic [31:0] q;
    int          n;
    n = 0;
    while (irq !== 1'h1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) err_total++;
    wb_io(1'h0, 6'h10, 32'h0, q);
    `CHK(q, {11'h000, ch, 4'h0, 4'hA, 3'h0, ch})
    for (int i = 0; i < nch; i++) `CHK(chq[i], ch - 5'(nch - 1 - i))
    chq.delete();
    wb_io(1'h1, 6'h14, 32'h7, q);
  endtask : chk_res
  // reset values, conversion clamp, unmapped read and ignored triggers
  task automatic t_regs();
    logic [5:0]  ofs [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h20};
    logic [31:0] rv  [8] = '{32'h0, 32'h0, 32'h1B, 32'h3F, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] q;
    foreach (ofs[i]) begin
      wb_io(1'h0, ofs[i], 32'h0, q);
      `CHK(q, rv[i])
    end
    wb_io(1'h1, 6'h0C, 32'h10, q);
    wb_io(1'h0, 6'h0C, 32'h0, q);
    `CHK(q, 32'h3F)
    wb_io(1'h1, 6'h08, 32'h2, q);
    wb_io(1'h1, 6'h18, 32'h1, q);
    fire <= 4'hF;
    repeat (8) @(posedge clk_i);
    fire <= 4'h0;
    repeat (8) @(posedge clk_i);
    `CHK(chq.size(), 0)
  endtask : t_regs
  // single channel software one-shot over external and internal codes
  task automatic t_chans();
    logic [4:0]  cl [6] = '{5'h00, 5'h0E, 5'h10, 5'h11, 5'h12, 5'h13};
    logic [31:0] q;
    foreach (cl[i]) begin
      wb_io(1'h1, 6'h04, {27'h0, cl[i]}, q);
      wb_io(1'h1, 6'h00, 32'h1, q);
      chk_res(cl[i], 1);
      wb_io(1'h0, 6'h00, 32'h0, q);
      `CHK(q[0], 1'h0)
    end
  endtask : t_chans
  // four channel scan, interrupt on pass end only, then masked clear
  task automatic t_scan();
    logic [31:0] q;
    wb_io(1'h1, 6'h18, 32'h2, q);
    wb_io(1'h1, 6'h04, 32'h3, q);
    wb_io(1'h1, 6'h00, 32'h9, q);
    chk_res(5'h06, 4);
    wb_io(1'h0, 6'h1C, 32'h0, q);
    `CHK(q, 32'h0000_0300)
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'h0)
    wb_io(1'h1, 6'h18, 32'h1, q);
  endtask : t_scan
  // hardware triggers: wrong input ignored, wait mode powers on demand
  task automatic t_hw();
    logic [31:0] q;
    int          n;
    wb_io(1'h1, 6'h04, 32'h7, q);
    wb_io(1'h1, 6'h00, 32'h43, q);
    `CHK(ana.pwr, 1'h1)
    fire <= 4'h2;
    repeat (12) @(posedge clk_i);
    fire <= 4'h4;
    `CHK(chq.size(), 0)
    chk_res(5'h07, 1);
    fire <= 4'h0;
    wb_io(1'h1, 6'h00, 32'h5, q);
    `CHK(ana.pwr, 1'h0)
    fire <= 4'h1;
    n = 0;
    while (ana.pwr !== 1'h1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (ana.sample !== 1'h1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n >= STAB, 1'h1)
    chk_res(5'h07, 1);
    fire <= 4'h0;
    wb_io(1'h1, 6'h00, 32'h0, q);
  endtask : t_hw
  // sequential mode repeats until run is cleared
  task automatic t_seq();
    logic [31:0] q;
    wb_io(1'h1, 6'h04, 32'h9, q);
    wb_io(1'h1, 6'h00, 32'h11, q);
    chk_res(5'h09, 1);
    chk_res(5'h09, 1);
    wb_io(1'h1, 6'h00, 32'h0, q);
    repeat (4) @(posedge clk_i);
    `CHK(ana.sample | ana.convert, 1'h0)
  endtask : t_seq
  // verdict and end of run
  task automatic stop_test();
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    err_total = 0;
    checked = 0;
    rst_i = 1'h1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 6'h00;
    wb_sel = 4'hF;
    wb_wdat = 32'h0;
    fire = 4'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_regs();
    t_chans();
    t_scan();
    t_hw();
    t_seq();
    stop_test();
  end
  // watchdog cuts a hang short
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
endmodule : acs_sequencer_tb_top
bind acs_sequencer acs_sva u_acs_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hw_trig_i(hw_trig_i),
  .adc_data_i(adc_data_i), .ana_o(ana_o), .irq_o(irq_o));

// ==== dv/acs_sva.sv ====
// acs_sva: bus handshake and analog phase checks on the sequencer ports.
// assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module acs_sva (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [5:0]                 wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic [acs_pkg::TRIG_N-1:0] hw_trig_i,
  input wire logic [acs_pkg::RES_W-1:0]  adc_data_i,
  input wire acs_pkg::acs_ana_type       ana_o,
  input wire logic                       irq_o
);
  // cycles spent in the running conversion phase
  logic [7:0] conv_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !ana_o.convert) begin
      conv_cnt_r <= 8'h00;
    end else begin
      conv_cnt_r <= conv_cnt_r + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request not yet answered
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // a bus access just completed; clearing run may abort a phase
  sequence bus_done_s;
    $past(wb_ack_o) || $past(wb_ack_o, 2);
  endsequence
  ack_answer_a: assert property (req_s |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  unmapped_zero_a: assert property (req_s ##0 (!wb_we_i && wb_adr_i >= 6'h20)
    |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  phase_excl_a: assert property (!(ana_o.sample && ana_o.convert))
    else $error("sampling and conversion overlap");
  power_phase_a: assert property ((ana_o.sample || ana_o.convert) |-> ana_o.pwr)
    else $error("phase active while unpowered");
  chan_hold_a: assert property (ana_o.convert |-> $stable(ana_o.chan))
    else $error("channel changed during conversion");
  chan_legal_a: assert property (ana_o.sample |-> (ana_o.chan <= 5'h0E ||
    ana_o.chan inside {[5'h10:5'h13]}))
    else $error("illegal channel code sampled");
  conv_len_a: assert property ($fell(ana_o.convert) |->
    (conv_cnt_r >= 8'h20) or bus_done_s) else $error("conversion too short");
  samp_conv_a: assert property ($fell(ana_o.sample) |->
    ana_o.convert or bus_done_s) else $error("sampling not followed by conversion");
endmodule : acs_sva
